// *** hw/adc_processing_select_power_ctrl.sv ***
`timescale 1ns/1ps
`include "adc_ctrl_consts.svh"

module adc_processing_select_power_ctrl
	import adc_ctrl_pkg::*;
(
	input wire logic MCLK,
	input wire logic SRST,
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic [7:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	output logic [7:0] REG_RDATA,
	input wire logic FRAME_START,
	input wire logic SAMPLE_TICK,
	input wire volume_pair_t VOLUME_TARGET,
	output volume_pair_t VOLUME_APPLIED,
	output logic INSTRUCTION_MODE,
	output logic [17:0] FIXED_BLOCK_SEL,
	output logic COND_A,
	output logic COND_B,
	output logic COUNTER_RESTART,
	output logic LEFT_POWER_UP,
	output logic RIGHT_POWER_UP
);

	// ****************************************
	// Register file
	// ****************************************
	regs_state_t state_reg;
	regs_state_t state_next;

	always_comb begin
		state_next = state_reg;
		if (REG_WR) begin
			// Reserved bits are masked so they always read back as reset
			case (REG_ADDR)
				`OFS_RECORD_PROCESSING_SELECT:
					state_next.proc_select = REG_WDATA & `MSK_SELECT;
				`OFS_INSTRUCTION_MODE_CONTROL:
					state_next.mode_control = REG_WDATA & `MSK_MODE_CONTROL;
				`OFS_CONVERTER_POWER_SOFTSTEP:
					state_next.power_step = REG_WDATA & `MSK_POWER_SOFTSTEP;
				default: state_next.proc_select = state_reg.proc_select;
			endcase
		end
		if (REG_RD) begin
			case (REG_ADDR)
				`OFS_RECORD_PROCESSING_SELECT: state_next.read_data = state_reg.proc_select;
				`OFS_INSTRUCTION_MODE_CONTROL: state_next.read_data = state_reg.mode_control;
				`OFS_CONVERTER_POWER_SOFTSTEP: state_next.read_data = state_reg.power_step;
				default: state_next.read_data = `READ_UNDEFINED;
			endcase
		end
	end

	always_ff @(posedge MCLK) begin
		if (SRST) begin
			state_reg.proc_select <= `RST_RECORD_PROCESSING_SELECT;
			state_reg.mode_control <= `RST_INSTRUCTION_MODE_CONTROL;
			state_reg.power_step <= `RST_CONVERTER_POWER_SOFTSTEP;
			state_reg.read_data <= 8'h00;
		end else begin
			state_reg <= state_next;
		end
	end

	assign REG_RDATA = state_reg.read_data;

	// ****************************************
	// Processing selection
	// ****************************************
	logic [4:0] sel;
	assign sel = state_reg.proc_select[4:0];
	assign INSTRUCTION_MODE = (sel == `SEL_INSTRUCTION_MODE);

	// Reserved codes light no block; software keeps out of them
	generate
		for (genvar i = 0; i < 18; i++) begin : g_block
			assign FIXED_BLOCK_SEL[i] = (sel == 5'(i + 1));
		end
	endgenerate

	// ****************************************
	// Instruction mode control and power
	// ****************************************
	assign COND_A = state_reg.mode_control[`BIT_COND_A];
	assign COND_B = state_reg.mode_control[`BIT_COND_B];
	assign COUNTER_RESTART = FRAME_START
		&& !state_reg.mode_control[`BIT_NO_FRAME_RESTART];
	assign LEFT_POWER_UP = state_reg.power_step[`BIT_LEFT_POWER];
	assign RIGHT_POWER_UP = state_reg.power_step[`BIT_RIGHT_POWER];

	// ****************************************
	// Volume soft-stepping
	// ****************************************
	volume_stepper u_left (
		.clk(MCLK),
		.srst(SRST),
		.sample_tick(SAMPLE_TICK),
		.step_rate(state_reg.power_step[1:0]),
		.target(VOLUME_TARGET.left),
		.applied(VOLUME_APPLIED.left)
	);

	volume_stepper u_right (
		.clk(MCLK),
		.srst(SRST),
		.sample_tick(SAMPLE_TICK),
		.step_rate(state_reg.power_step[1:0]),
		.target(VOLUME_TARGET.right),
		.applied(VOLUME_APPLIED.right)
	);

	// ****************************************
	// Checks
	// ****************************************
	a_select_reset: assert property (@(posedge MCLK)
		$past(SRST) |-> (FIXED_BLOCK_SEL == 18'h00001 && !INSTRUCTION_MODE))
		else $error("Reset does not select block one");

	a_instr_mode: assert property (@(posedge MCLK) disable iff (SRST)
		(REG_WR && REG_ADDR == `OFS_RECORD_PROCESSING_SELECT && REG_WDATA[4:0] == 5'h00)
		|=> (INSTRUCTION_MODE && FIXED_BLOCK_SEL == 18'h00000))
		else $error("Instruction mode not entered");

	a_instr_exit: assert property (@(posedge MCLK) disable iff (SRST)
		(REG_WR && REG_ADDR == `OFS_RECORD_PROCESSING_SELECT && REG_WDATA[4:0] != 5'h00)
		|=> !INSTRUCTION_MODE)
		else $error("Instruction mode kept for a fixed block code");

	a_block_decode: assert property (@(posedge MCLK) disable iff (SRST)
		(REG_WR && REG_ADDR == `OFS_RECORD_PROCESSING_SELECT && REG_WDATA[4:0] != 5'h00
		&& REG_WDATA[4:0] <= `SEL_LAST_FIXED_BLOCK)
		|=> (FIXED_BLOCK_SEL == (18'h00001 << ($past(REG_WDATA[4:0]) - 5'h01))))
		else $error("Wrong fixed block selected");

	// At most one block may be lit, and none while instruction mode is selected
	a_block_onehot: assert property (@(posedge MCLK) disable iff (SRST)
		$onehot0(FIXED_BLOCK_SEL) && (!INSTRUCTION_MODE || FIXED_BLOCK_SEL == 18'h00000))
		else $error("More than one processing path selected");

	a_cond_bits: assert property (@(posedge MCLK) disable iff (SRST)
		(REG_WR && REG_ADDR == `OFS_INSTRUCTION_MODE_CONTROL)
		|=> (COND_A == $past(REG_WDATA[6]) && COND_B == $past(REG_WDATA[5])))
		else $error("Condition bits not taken");

	a_cond_hold: assert property (@(posedge MCLK) disable iff (SRST)
		!(REG_WR && REG_ADDR == `OFS_INSTRUCTION_MODE_CONTROL)
		|=> ($stable(COND_A) && $stable(COND_B)))
		else $error("Condition bits changed without a write");

	a_mode_reset: assert property (@(posedge MCLK)
		$past(SRST) |-> (!COND_A && !COND_B))
		else $error("Condition bits not cleared by reset");

	a_restart_gate: assert property (@(posedge MCLK) disable iff (SRST)
		COUNTER_RESTART |-> (FRAME_START && !state_reg.mode_control[4]))
		else $error("Restart not gated");

	a_restart_follow: assert property (@(posedge MCLK) disable iff (SRST)
		(REG_WR && REG_ADDR == `OFS_INSTRUCTION_MODE_CONTROL)
		##1 !(REG_WR && REG_ADDR == `OFS_INSTRUCTION_MODE_CONTROL) ##1 FRAME_START
		|-> (COUNTER_RESTART == !$past(REG_WDATA[`BIT_NO_FRAME_RESTART], 2)))
		else $error("Restart does not follow the written bit");

	a_power_bits: assert property (@(posedge MCLK) disable iff (SRST)
		(REG_WR && REG_ADDR == `OFS_CONVERTER_POWER_SOFTSTEP)
		|=> (LEFT_POWER_UP == $past(REG_WDATA[7])
		&& RIGHT_POWER_UP == $past(REG_WDATA[6])))
		else $error("Power bits not taken");

	a_power_hold: assert property (@(posedge MCLK) disable iff (SRST)
		!(REG_WR && REG_ADDR == `OFS_CONVERTER_POWER_SOFTSTEP)
		|=> ($stable(LEFT_POWER_UP) && $stable(RIGHT_POWER_UP)))
		else $error("Power bits changed without a write");

	a_power_reset: assert property (@(posedge MCLK)
		$past(SRST) |-> (!LEFT_POWER_UP && !RIGHT_POWER_UP))
		else $error("Channels not powered down by reset");

	a_power_read: assert property (@(posedge MCLK) disable iff (SRST)
		(REG_RD && REG_ADDR == `OFS_CONVERTER_POWER_SOFTSTEP)
		|=> (REG_RDATA[7] == $past(LEFT_POWER_UP)
		&& REG_RDATA[6] == $past(RIGHT_POWER_UP)))
		else $error("Power bits read back wrong");

	a_reserved_zero: assert property (@(posedge MCLK) disable iff (SRST)
		REG_RD && REG_ADDR == `OFS_INSTRUCTION_MODE_CONTROL
		|=> (REG_RDATA[7] == 1'b0 && REG_RDATA[3:0] == 4'h0))
		else $error("Reserved bits read non-reset");

	a_select_reserved: assert property (@(posedge MCLK) disable iff (SRST)
		REG_RD && REG_ADDR == `OFS_RECORD_PROCESSING_SELECT
		|=> (REG_RDATA[7:5] == 3'h0))
		else $error("Reserved select bits read non-reset");

	a_power_reserved: assert property (@(posedge MCLK) disable iff (SRST)
		REG_RD && REG_ADDR == `OFS_CONVERTER_POWER_SOFTSTEP
		|=> (REG_RDATA[5:2] == 4'h0))
		else $error("Reserved power bits read non-reset");

	a_unmapped_read: assert property (@(posedge MCLK) disable iff (SRST)
		(REG_RD && REG_ADDR != `OFS_RECORD_PROCESSING_SELECT
		&& REG_ADDR != `OFS_INSTRUCTION_MODE_CONTROL
		&& REG_ADDR != `OFS_CONVERTER_POWER_SOFTSTEP)
		|=> (REG_RDATA == `READ_UNDEFINED))
		else $error("Unmapped read returned live data");

endmodule // adc_processing_select_power_ctrl

// *** include/adc_ctrl_consts.svh ***
`ifndef ADC_CTRL_CONSTS_SVH
`define ADC_CTRL_CONSTS_SVH

// ****************************************
// Register offsets
// ****************************************
`define OFS_RECORD_PROCESSING_SELECT 8'h3D
`define OFS_INSTRUCTION_MODE_CONTROL 8'h3E
`define OFS_CONVERTER_POWER_SOFTSTEP 8'h51
`define OFS_RESERVED_LO 8'h3F
`define OFS_RESERVED_HI 8'h50

// ****************************************
// Reset values and fields
// ****************************************
`define RST_RECORD_PROCESSING_SELECT 8'h01
`define RST_INSTRUCTION_MODE_CONTROL 8'h00
`define RST_CONVERTER_POWER_SOFTSTEP 8'h00
`define SEL_INSTRUCTION_MODE 5'h00
`define SEL_LAST_FIXED_BLOCK 5'h12
`define MSK_SELECT 8'h1F
`define MSK_MODE_CONTROL 8'h70
`define MSK_POWER_SOFTSTEP 8'hC3
`define BIT_COND_A 6
`define BIT_COND_B 5
`define BIT_NO_FRAME_RESTART 4
`define BIT_LEFT_POWER 7
`define BIT_RIGHT_POWER 6
`define STEP_EVERY_SAMPLE 2'h0
`define STEP_EVERY_SECOND 2'h1
`define STEP_DIRECT 2'h2
`define READ_UNDEFINED 8'h00

`endif

// *** include/adc_ctrl_pkg.sv ***
package adc_ctrl_pkg;

	typedef struct packed {
		logic [7:0] proc_select;
		logic [7:0] mode_control;
		logic [7:0] power_step;
		logic [7:0] read_data;
	} regs_state_t;

	typedef struct packed {
		logic [6:0] left;
		logic [6:0] right;
	} volume_pair_t;

	typedef struct packed {
		logic [6:0] current;
		logic skip_phase;
	} step_state_t;

	typedef enum logic [1:0] {
		STEP_ONE_PER_SAMPLE,
		STEP_ONE_PER_TWO,
		STEP_IMMEDIATE
	} step_mode_t;

endpackage

// *** hw/volume_stepper.sv ***
`timescale 1ns/1ps
`include "adc_ctrl_consts.svh"

// Walks the applied volume toward the target, one gain step per allowed sample tick, or jumps straight to it at STEP_DIRECT.
module volume_stepper
	import adc_ctrl_pkg::*;
(
	input wire logic clk,
	input wire logic srst,
	input wire logic sample_tick,
	input wire logic [1:0] step_rate,
	input wire logic [6:0] target,
	output logic [6:0] applied
);

	step_state_t state_reg;
	step_state_t state_next;
	logic [6:0] diff;
	logic may_step;

	always_comb begin
		state_next = state_reg;
		diff = 7'(target - state_reg.current);
		may_step = 1'b0;
		case (step_rate)
			`STEP_EVERY_SAMPLE: may_step = sample_tick;
			`STEP_EVERY_SECOND: may_step = sample_tick && state_reg.skip_phase;
			default: may_step = 1'b0;
		endcase
		if (sample_tick) begin
			state_next.skip_phase = ~state_reg.skip_phase;
		end
		if (step_rate == `STEP_DIRECT) begin
			state_next.current = target;
		end else if (may_step && diff != 7'h00) begin
			// Signed compare so stepping wraps through the two's complement codes correctly
			if ($signed(target) > $signed(state_reg.current)) begin
				state_next.current = 7'(state_reg.current + 7'h01);
			end else begin
				state_next.current = 7'(state_reg.current - 7'h01);
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign applied = state_reg.current;

	a_direct_apply: assert property (@(posedge clk) disable iff (srst)
		(step_rate == `STEP_DIRECT) |=> (applied == $past(target)))
		else $error("Direct volume not applied");

	a_step_size: assert property (@(posedge clk) disable iff (srst)
		(step_rate != `STEP_DIRECT && $past(step_rate) != `STEP_DIRECT)
		|-> (applied == $past(applied) || applied == 7'($past(applied) + 7'h01)
		|| applied == 7'($past(applied) - 7'h01)))
		else $error("Volume moved more than one step");

	a_no_step_idle: assert property (@(posedge clk) disable iff (srst)
		(!sample_tick && step_rate != `STEP_DIRECT) |=> $stable(applied))
		else $error("Volume stepped without sample tick");

endmodule // volume_stepper

// *** verif/host_model.sv ***
`timescale 1ns/1ps
`include "adc_ctrl_consts.svh"

// ****************************************
// Control-bus host, one strobe per access
// ****************************************
module host_model (
	input wire logic mclk,
	output logic reg_wr,
	output logic reg_rd,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata
);
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
	end
	// Reserved bits always go out at reset value, so masks double as the write filter
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] m;
		m = (a == `OFS_RECORD_PROCESSING_SELECT) ? `MSK_SELECT : `MSK_POWER_SOFTSTEP;
		if (a == `OFS_INSTRUCTION_MODE_CONTROL) m = `MSK_MODE_CONTROL;
		if (a >= `OFS_RESERVED_LO && a <= `OFS_RESERVED_HI) return;
		if (a == `OFS_RECORD_PROCESSING_SELECT && (d & m) > 8'(`SEL_LAST_FIXED_BLOCK))
			return;
		if (a == `OFS_CONVERTER_POWER_SOFTSTEP && d[1:0] == 2'h3) return;
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d & m;
		@(posedge mclk);
		reg_wr <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~(d & m);
		#1;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge mclk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		#1;
		d = reg_rdata;
	endtask
endmodule // host_model

// *** verif/testbench.sv ***
`timescale 1ns/1ps
`include "adc_ctrl_consts.svh"

// ****************************************
// Register bank bench
// ****************************************
module testbench
	import adc_ctrl_pkg::*;
;
	logic mclk = 1'b0;
	logic srst = 1'b1;
	logic frame_start = 1'b0;
	logic sample_tick = 1'b0;
	volume_pair_t tgt = '0;
	volume_pair_t app;
	logic reg_wr, reg_rd, imode, cond_a, cond_b, restart, lpow, rpow;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, v;
	logic [17:0] fsel;
	int n_errors = 0;
	int n_compared = 0;
	int cycles = 0;
	always #5 mclk = ~mclk;
	host_model host (.mclk(mclk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
	adc_processing_select_power_ctrl dut (.MCLK(mclk), .SRST(srst), .REG_WR(reg_wr),
		.REG_RD(reg_rd), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata),
		.FRAME_START(frame_start), .SAMPLE_TICK(sample_tick), .VOLUME_TARGET(tgt),
		.VOLUME_APPLIED(app), .INSTRUCTION_MODE(imode), .FIXED_BLOCK_SEL(fsel),
		.COND_A(cond_a), .COND_B(cond_b), .COUNTER_RESTART(restart),
		.LEFT_POWER_UP(lpow), .RIGHT_POWER_UP(rpow));
	task automatic report_and_stop();
		if (n_errors == 0 && n_compared > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// A hung bus task would otherwise stall the run forever
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 5000) begin
			n_errors++;
			report_and_stop();
		end
	end
	task automatic chk(input string name, input logic [17:0] exp, input logic [17:0] got);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic t_reset();
		host.wr(`OFS_CONVERTER_POWER_SOFTSTEP, 8'hC1);
		@(posedge mclk) srst <= 1'b1;
		repeat (2) @(posedge mclk);
		srst <= 1'b0;
		host.rd(`OFS_RECORD_PROCESSING_SELECT, v);
		chk("sel_rst", `RST_RECORD_PROCESSING_SELECT, v);
		chk("blk_rst", 18'h00001, fsel);
		host.rd(`OFS_INSTRUCTION_MODE_CONTROL, v);
		chk("mode_rst", `RST_INSTRUCTION_MODE_CONTROL, v);
		host.rd(`OFS_CONVERTER_POWER_SOFTSTEP, v);
		chk("pow_rst", `RST_CONVERTER_POWER_SOFTSTEP, v);
	endtask
	task automatic t_select();
		for (int c = 18; c >= 0; c--) begin
			host.wr(`OFS_RECORD_PROCESSING_SELECT, 8'(c));
			chk("imode", 18'(c == 0), imode);
			chk("blk", (c == 0) ? 18'h0 : 18'h1 << (c - 1), fsel);
			host.rd(`OFS_RECORD_PROCESSING_SELECT, v);
			chk("sel_rd", 18'(c), v);
		end
	endtask
	task automatic t_mode();
		logic [7:0] d [5] = '{8'h40, 8'h20, 8'h10, 8'h70, 8'h00};
		foreach (d[i]) begin
			host.wr(`OFS_INSTRUCTION_MODE_CONTROL, d[i]);
			@(posedge mclk) frame_start <= 1'b1;
			#1 chk("restart", !d[i][4], restart);
			@(posedge mclk) frame_start <= 1'b0;
			#1 chk("restart_idle", 1'b0, restart);
			host.rd(`OFS_INSTRUCTION_MODE_CONTROL, v);
			chk("mode_rd", d[i], v);
			chk("cond_a", d[i][6], cond_a);
			chk("cond_b", d[i][5], cond_b);
		end
	endtask
	task automatic t_power();
		logic [7:0] d [4] = '{8'h80, 8'h40, 8'hC0, 8'h00};
		foreach (d[i]) begin
			host.wr(`OFS_CONVERTER_POWER_SOFTSTEP, d[i]);
			chk("left_pow", d[i][7], lpow);
			chk("right_pow", d[i][6], rpow);
		end
		host.rd(8'h3F, v);
		chk("unmapped_lo", `READ_UNDEFINED, v);
		host.rd(8'h50, v);
		chk("unmapped_hi", `READ_UNDEFINED, v);
	endtask
	task automatic ticks(input int n);
		repeat (n) begin
			@(posedge mclk) sample_tick <= 1'b1;
			@(posedge mclk) sample_tick <= 1'b0;
		end
		#1;
	endtask
	task automatic t_volume();
		@(posedge mclk) tgt <= '{left: 7'h03, right: 7'h7E};
		ticks(1);
		chk("vol_l1", 7'h01, app.left);
		chk("vol_r1", 7'h7F, app.right);
		ticks(2);
		chk("vol_l3", 7'h03, app.left);
		chk("vol_r3", 7'h7E, app.right);
		host.wr(`OFS_CONVERTER_POWER_SOFTSTEP, 8'(`STEP_EVERY_SECOND));
		@(posedge mclk) tgt <= '{left: 7'h06, right: 7'h7E};
		ticks(2);
		chk("vol_half", 7'h04, app.left);
		host.wr(`OFS_CONVERTER_POWER_SOFTSTEP, 8'(`STEP_DIRECT));
		@(posedge mclk) tgt <= '{left: 7'h28, right: 7'h68};
		repeat (2) @(posedge mclk);
		#1 chk("vol_direct", {7'h28, 7'h68}, app);
	endtask
	initial begin
		repeat (5) @(posedge mclk);
		srst <= 1'b0;
		t_reset();
		t_select();
		t_mode();
		t_power();
		t_volume();
		report_and_stop();
	end
endmodule // testbench
